// File: verilog/pcs_regs.svh
// register offsets, field positions, field values and fixed constants of the capability bank
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

// byte addresses, axi4-lite, one word each
`define PCS_ADDR_NEXT_PTR    12'h000
`define PCS_ADDR_PCIE_CAP    12'h004
`define PCS_ADDR_DEV_CAP     12'h008
`define PCS_ADDR_DEV_CAP2    12'h00C
`define PCS_ADDR_LINK_CAP    12'h010
`define PCS_ADDR_MSI_CTRL    12'h014
`define PCS_ADDR_AER_HDR     12'h018
`define PCS_ADDR_DSN_HDR     12'h01C
`define PCS_ADDR_DSN_LO      12'h020
`define PCS_ADDR_DSN_HI      12'h024
`define PCS_ADDR_PMC         12'h028
`define PCS_ADDR_PM_CONS     12'h02C
`define PCS_ADDR_PM_DISS     12'h030
`define PCS_ADDR_PM_SCALE    12'h034
`define PCS_ADDR_CFG_CTRL    12'h038
`define PCS_ADDR_EXT_PTR     12'h03C
`define PCS_ADDR_STATUS      12'h040

// field values and field positions
`define PCS_CAP_VER_V2       4'h2
`define PCS_AER_VER          4'h1
`define PCS_DSN_VER          4'h1
`define PCS_MSI_EN_BIT       0
`define PCS_TERM_BIT         0
`define PCS_RO_BIT           0
`define PCS_LW_LO            4
`define PCS_LW_HI            9
`define PCS_MSI_REQ_LO       1
`define PCS_MSI_REQ_HI       3
`define PCS_MSI_GNT_LO       4
`define PCS_MSI_GNT_HI       6
`define PCS_MPS_LO           0
`define PCS_MPS_HI           2
`define PCS_DEVCAP_LO        3
`define PCS_DEVCAP_HI        27
`define PCS_PMC_LO           16
`define PCS_PMC_HI           31
`define PCS_VER_LO           16
`define PCS_VER_HI           19

// axi responses
`define PCS_RESP_OKAY        2'h0
`define PCS_RESP_SLVERR      2'h2

// retry buffer: smallest option 512 bytes
`define PCS_RETRY_MIN_BYTES  16'h0200
`define PCS_MPS_256          3'h1
`define PCS_MPS_512          3'h2
`define PCS_MPS_UNIT_BYTES   16'h0080

`endif

// File: verilog/pcs_pkg.sv
// types shared by the capability bank
package pcs_pkg;
   typedef enum logic [1:0] {PCS_W_IDLE, PCS_W_RESP} pcs_wstate_t;
   typedef enum logic [0:0] {PCS_R_IDLE, PCS_R_RESP} pcs_rstate_t;
endpackage

// File: verilog/pcs_msi_sync.sv
// three-flop input synchroniser with agreement filter for one multi-bit pin group
`timescale 1ns/1ns
`default_nettype none
module pcs_msi_sync
   import pcs_pkg::*;
#(
   parameter int W = 3
)
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // asynchronous in, filtered out
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] val;
   } pcs_sync_t;

   pcs_sync_t q;
   pcs_sync_t d;

   always_comb
   begin
      d    = q;
      d.s1 = din;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // change counts only once second and third agree
      if (q.s2 == q.s3)
      begin
         d.val = q.s3;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign dout = q.val;
endmodule
`default_nettype wire

// File: verilog/pcs_cap_bank.sv
// pcie capability structure register bank with axi4-lite view
`timescale 1ns/1ns
`default_nettype none
`include "pcs_regs.svh"
module pcs_cap_bank
   import pcs_pkg::*;
#(
   parameter logic [7:0]  NEXT_CAP_PTR    = 8'h00,
   parameter logic [3:0]  PCIE_CAP_VER    = `PCS_CAP_VER_V2,
   parameter logic [2:0]  MAX_PAYLOAD     = 3'h0,
   parameter logic [24:0] DEV_CAP_27_3    = 25'h000_0000,
   parameter logic        RELAXED_ORDER   = 1'b1,
   parameter logic [5:0]  MAX_LINK_WIDTH  = 6'h04,
   parameter logic [4:0]  DEV_CAP2_4_0    = 5'h00,
   parameter logic        USE_MSI         = 1'b1,
   parameter logic [2:0]  MSI_REQ_LOG2    = 3'h0,
   parameter logic        USE_AER         = 1'b0,
   parameter logic [63:0] SERIAL_NUMBER   = 64'h0000_0000_0000_0000,
   parameter logic [15:0] PMC_31_16       = 16'h0000,
   parameter logic [1:0]  DATA_SCALE      = 2'h0,
   parameter logic [31:0] PWR_CONSUMED    = 32'h0000_0000,
   parameter logic [31:0] PWR_DISSIPATED  = 32'h0000_0000,
   parameter logic        TERMINATE_CFG   = 1'b0,
   parameter logic [11:0] USER_EXT_PTR    = 12'h000
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // axi4-lite write address
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // msi grant from the link side
   input  wire logic [2:0]  msi_grant_in,
   output logic [2:0]       msi_granted_count,
   // config request routing
   input  wire logic        cfg_req_valid,
   output logic             cfg_req_to_user,
   output logic             cfg_req_done_internal,
   output logic             internal_cfg_request_completion,
   // datapath sizing and status
   output logic [15:0]      retry_buf_bytes,
   output logic             relaxed_order_cap,
   output logic             msi_cap_present,
   output logic             aer_cap_present
);
   typedef struct packed
   {
      pcs_wstate_t  wst;
      pcs_rstate_t  rst;
      logic         aw_got;
      logic         w_got;
      logic [11:0]  aw_addr;
      logic [31:0]  wdata;
      logic [3:0]   wstrb;
      logic [1:0]   bresp;
      logic [31:0]  rdata;
      logic [1:0]   rresp;
      logic [31:0]  scratch;
      logic         term_q;
      logic         req_user;
      logic         req_int;
   } pcs_state_t;

   pcs_state_t q;
   pcs_state_t d;
   logic [2:0] grant_sync;
   logic [2:0] mps_clamped;

   pcs_msi_sync #(.W(3)) u_msi_sync
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     (msi_grant_in),
      .dout    (grant_sync)
   );

   // retry buffer never smaller than 512B
   assign mps_clamped = (MAX_PAYLOAD <= `PCS_MPS_256) ? `PCS_MPS_512 : MAX_PAYLOAD;

   function automatic logic [31:0] rd_word(input logic [11:0] a, input logic term,
                                           input logic [2:0] granted, input logic [31:0] scr);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         `PCS_ADDR_NEXT_PTR: v[7:0] = NEXT_CAP_PTR;
         `PCS_ADDR_PCIE_CAP: v[`PCS_VER_HI:`PCS_VER_LO] = PCIE_CAP_VER;
         `PCS_ADDR_DEV_CAP:
         begin
            v[`PCS_MPS_HI:`PCS_MPS_LO] = MAX_PAYLOAD;
            v[`PCS_DEVCAP_HI:`PCS_DEVCAP_LO] = DEV_CAP_27_3;
         end
         `PCS_ADDR_DEV_CAP2: v[4:0] = DEV_CAP2_4_0;
         `PCS_ADDR_LINK_CAP:
         begin
            v[`PCS_LW_HI:`PCS_LW_LO] = MAX_LINK_WIDTH;
            v[`PCS_RO_BIT] = RELAXED_ORDER;
         end
         `PCS_ADDR_MSI_CTRL:
         begin
            v[`PCS_MSI_EN_BIT] = USE_MSI;
            v[`PCS_MSI_REQ_HI:`PCS_MSI_REQ_LO] = USE_MSI ? MSI_REQ_LOG2 : 3'h0;
            v[`PCS_MSI_GNT_HI:`PCS_MSI_GNT_LO] = granted;
         end
         `PCS_ADDR_AER_HDR: v[`PCS_VER_HI:`PCS_VER_LO] = USE_AER ? `PCS_AER_VER : 4'h0;
         `PCS_ADDR_DSN_HDR: v[`PCS_VER_HI:`PCS_VER_LO] = `PCS_DSN_VER;
         `PCS_ADDR_DSN_LO:  v = SERIAL_NUMBER[31:0];
         `PCS_ADDR_DSN_HI:  v = SERIAL_NUMBER[63:32];
         `PCS_ADDR_PMC:     v[`PCS_PMC_HI:`PCS_PMC_LO] = PMC_31_16;
         `PCS_ADDR_PM_CONS: v = PWR_CONSUMED;
         `PCS_ADDR_PM_DISS: v = PWR_DISSIPATED;
         `PCS_ADDR_PM_SCALE: v[1:0] = DATA_SCALE;
         `PCS_ADDR_CFG_CTRL: v[`PCS_TERM_BIT] = term;
         `PCS_ADDR_EXT_PTR: v[11:0] = USER_EXT_PTR;
         `PCS_ADDR_STATUS:  v = scr;
         default:           v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      return (a <= `PCS_ADDR_STATUS) && (a[1:0] == 2'h0);
   endfunction

   always_comb
   begin
      d = q;
      // write path: address and data taken in either order
      if (q.wst == PCS_W_IDLE)
      begin
         if (s_axi_awvalid && !q.aw_got)
         begin
            d.aw_got  = 1'b1;
            d.aw_addr = s_axi_awaddr;
         end
         if (s_axi_wvalid && !q.w_got)
         begin
            d.w_got = 1'b1;
            // data may be taken before its address, so hold it
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
         end
         if (d.aw_got && d.w_got)
         begin
            d.wst   = PCS_W_RESP;
            d.bresp = mapped(d.aw_addr) ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
            // only the control word and scratch hold; parameter fields ignore writes
            if (d.aw_addr == `PCS_ADDR_CFG_CTRL && d.wstrb[0])
            begin
               d.term_q = d.wdata[`PCS_TERM_BIT];
            end
            else if (d.aw_addr == `PCS_ADDR_STATUS)
            begin
               for (int i = 0; i < 4; i++)
               begin
                  if (d.wstrb[i])
                  begin
                     d.scratch[i*8 +: 8] = d.wdata[i*8 +: 8];
                  end
               end
            end
            // other mapped words are read-only: write dropped
         end
      end
      else if (s_axi_bready)
      begin
         d.wst    = PCS_W_IDLE;
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
      end
      // read path
      if (q.rst == PCS_R_IDLE)
      begin
         if (s_axi_arvalid)
         begin
            d.rst   = PCS_R_RESP;
            d.rdata = rd_word(s_axi_araddr, q.term_q, grant_sync, q.scratch);
            d.rresp = mapped(s_axi_araddr) ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
      begin
         d.rst = PCS_R_IDLE;
      end
      // config request routing, registered
      d.req_int  = cfg_req_valid && q.term_q;
      d.req_user = cfg_req_valid && !q.term_q;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         q         <= '0;
         q.wst     <= PCS_W_IDLE;
         q.rst     <= PCS_R_IDLE;
         q.term_q  <= TERMINATE_CFG;
      end
      else
      begin
         q <= d;
      end
   end

   assign s_axi_awready = (q.wst == PCS_W_IDLE) && !q.aw_got;
   assign s_axi_wready  = (q.wst == PCS_W_IDLE) && !q.w_got;
   assign s_axi_bvalid  = (q.wst == PCS_W_RESP);
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = (q.rst == PCS_R_IDLE);
   assign s_axi_rvalid  = (q.rst == PCS_R_RESP);
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;

   assign msi_granted_count               = USE_MSI ? grant_sync : 3'h0;
   assign internal_cfg_request_completion = q.term_q;
   assign cfg_req_done_internal           = q.req_int;
   assign cfg_req_to_user                 = q.req_user;
   // sized as 128 bytes shifted by the clamped code
   assign retry_buf_bytes  = 16'(`PCS_MPS_UNIT_BYTES << mps_clamped);
   assign relaxed_order_cap = RELAXED_ORDER; // no datapath change
   assign msi_cap_present  = USE_MSI;
   assign aer_cap_present  = USE_AER;
endmodule
`default_nettype wire

// File: verification/pcs_checker.sv
// assertions on the capability bank ports
`timescale 1ns/1ns
`default_nettype none
module pcs_checker
#(
   parameter logic [2:0] MAX_PAYLOAD   = 3'h0,
   parameter logic       RELAXED_ORDER = 1'h1,
   parameter logic       USE_MSI       = 1'h1,
   parameter logic       USE_AER       = 1'h0
)
(
   // clock and reset
   input wire logic        clk, sys_rst,
   // bus handshakes
   input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, s_axi_bvalid, s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_bresp,
   // sideband
   input wire logic [2:0]  msi_grant_in, msi_granted_count,
   input wire logic        cfg_req_valid, cfg_req_to_user, cfg_req_done_internal,
   input wire logic        internal_cfg_request_completion, relaxed_order_cap, msi_cap_present, aer_cap_present,
   input wire logic [15:0] retry_buf_bytes
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_grant_quiet;
      $stable(msi_grant_in) [*8];
   endsequence
   a_cfg_forward: assert property (cfg_req_valid && !internal_cfg_request_completion
      |=> cfg_req_to_user && !cfg_req_done_internal) else $error("request not forwarded");
   a_cfg_absorb: assert property (cfg_req_valid && internal_cfg_request_completion
      |=> !cfg_req_to_user && cfg_req_done_internal) else $error("request leaked to user");
   a_cfg_idle: assert property (!cfg_req_valid |=> !cfg_req_to_user && !cfg_req_done_internal)
      else $error("routing without request");
   // codes below 512 bytes share the smallest buffer
   a_retry_size: assert property (retry_buf_bytes == (16'h0080 << ((MAX_PAYLOAD < 3'h2) ? 3'h2 : MAX_PAYLOAD)))
      else $error("retry buffer size wrong");
   a_caps_const: assert property (relaxed_order_cap == RELAXED_ORDER && msi_cap_present == USE_MSI
      && aer_cap_present == USE_AER) else $error("capability flag wrong");
   a_msi_grant: assert property (s_grant_quiet |-> msi_granted_count == (USE_MSI ? msi_grant_in : 3'h0))
      else $error("granted count stale");
   a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid) else $error("read not answered");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
endmodule
bind pcs_cap_bank pcs_checker #(.MAX_PAYLOAD(MAX_PAYLOAD), .RELAXED_ORDER(RELAXED_ORDER), .USE_MSI(USE_MSI),
   .USE_AER(USE_AER)) chk_i (.clk, .sys_rst, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_bresp, .msi_grant_in, .msi_granted_count, .cfg_req_valid,
   .cfg_req_to_user, .cfg_req_done_internal, .internal_cfg_request_completion, .relaxed_order_cap,
   .msi_cap_present, .aer_cap_present, .retry_buf_bytes);
`default_nettype wire

// File: verification/pcs_rc_model.sv
// root complex stand-in: config requests and msi grant
`timescale 1ns/1ns
`default_nettype none
module pcs_rc_model
(
   // clock
   input wire logic       clk,
   // commands from the bench
   input wire logic       send_req,
   input wire logic [2:0] grant_code,
   // toward the bank
   output logic           cfg_req_valid,
   output logic [2:0]     msi_grant_in
);
   // bench commands forwarded to the bank one clock later through a register
   always_ff @(posedge clk)
   begin
      cfg_req_valid <= send_req;
      msi_grant_in <= grant_code;
   end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the capability bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam logic [24:0] DC  = 25'h0AB_CDEF;
   localparam logic [63:0] SN  = 64'h0123_4567_89AB_CDEF;
   localparam logic [15:0] PMC = 16'hC803;
   localparam logic [31:0] PC  = 32'h1122_3344;
   localparam logic [31:0] PD  = 32'h5566_7788;
   logic        clk = 1'h0, sys_rst = 1'h1, send_req = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [2:0]  grant_code = 3'h0, msi_grant_in, msi_granted_count;
   logic        cfg_req_valid, cfg_req_to_user, cfg_req_done_internal, internal_cfg_request_completion;
   logic        relaxed_order_cap, msi_cap_present, aer_cap_present;
   logic [15:0] retry_buf_bytes;
   int          mismatches = 0, check_count = 0, cycles = 0;
   logic [11:0] ta [15] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C, 12'h020,
                            12'h024, 12'h028, 12'h02C, 12'h030, 12'h034, 12'h03C};
   logic [31:0] tm [15] = '{32'h0000_00FF, 32'h000F_0000, 32'h0FFF_FFFF, 32'h0000_001F, 32'h0000_03F1,
      32'h0000_000F, 32'h000F_0000, 32'h000F_0000, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_0000,
      32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0003, 32'h0000_0FFF};
   logic [31:0] te [15] = '{32'h0000_0000, 32'h0002_0000, {4'h0, DC, 3'h0}, 32'h0000_0015, 32'h0000_0011,
      32'h0000_0007, 32'h0001_0000, 32'h0001_0000, SN[31:0], SN[63:32], {PMC, 16'h0000}, PC, PD,
      32'h0000_0002, 32'h0000_0000};
   // next pointer left at zero, so internal completion may be switched on
   pcs_cap_bank #(.DEV_CAP_27_3(DC), .MAX_LINK_WIDTH(6'h01), .DEV_CAP2_4_0(5'h15), .MSI_REQ_LOG2(3'h3),
      .USE_AER(1'h1), .SERIAL_NUMBER(SN), .PMC_31_16(PMC), .DATA_SCALE(2'h2), .PWR_CONSUMED(PC),
      .PWR_DISSIPATED(PD)) dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .msi_grant_in, .msi_granted_count, .cfg_req_valid, .cfg_req_to_user, .cfg_req_done_internal,
      .internal_cfg_request_completion, .retry_buf_bytes, .relaxed_order_cap, .msi_cap_present,
      .aer_cap_present);
   pcs_rc_model rc (.clk, .send_req, .grant_code, .cfg_req_valid, .msi_grant_in);
   always #20 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // readiness is judged at the falling edge, where it is settled for the next rising edge
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      bit taw, tw, got;
      got = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (int n = 0; n < 40 && !got; n++)
      begin
         @(negedge clk);
         taw = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         got = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         @(posedge clk);
         if (taw) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
         if (got) s_axi_bready <= 1'h0;
      end
      chk({31'h0, got}, 32'h0000_0001, "write answer");
   endtask
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      bit tar, got;
      got = 1'b0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (int n = 0; n < 40 && !got; n++)
      begin
         @(negedge clk);
         tar = s_axi_arvalid && s_axi_arready;
         got = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk);
         if (tar) s_axi_arvalid <= 1'h0;
         if (got) s_axi_rready <= 1'h0;
      end
      chk({31'h0, got}, 32'h0000_0001, "read answer");
   endtask
   task automatic t_const();
      chk({16'h0, retry_buf_bytes}, 32'h0000_0200, "retry size");
      chk({29'h0, relaxed_order_cap, msi_cap_present, aer_cap_present}, 32'h0000_0007, "cap flags");
      $display("constants test done");
   endtask
   task automatic t_map();
      for (int i = 0; i < 15; i++)
      begin
         axi_rd(ta[i], rd, rs);
         chk(rd & tm[i], te[i], "field");
         chk({30'h0, rs}, 32'h0000_0000, "read okay");
      end
      $display("map test done");
   endtask
   task automatic t_ro_write();
      for (int i = 0; i < 15; i++)
      begin
         axi_wr(ta[i], 32'hFFFF_FFFF, rs);
         chk({30'h0, rs}, 32'h0000_0000, "write okay");
      end
      t_map();
      $display("read-only test done");
   endtask
   task automatic t_unmapped();
      axi_wr(12'h100, 32'h1234_5678, rs);
      chk({30'h0, rs}, 32'h0000_0002, "unmapped write");
      axi_rd(12'h100, rd, rs);
      chk({rd[29:0], rs}, 32'h0000_0002, "unmapped read");
      axi_rd(12'h002, rd, rs);
      chk({30'h0, rs}, 32'h0000_0002, "misaligned read");
      axi_wr(12'h040, 32'hA5A5_5A5A, rs);
      axi_rd(12'h040, rd, rs);
      chk(rd, 32'hA5A5_5A5A, "scratch");
      $display("unmapped test done");
   endtask
   task automatic cfg_pulse(input logic [1:0] exp);
      @(posedge clk);
      send_req <= 1'h1;
      @(posedge clk);
      send_req <= 1'h0;
      @(posedge clk);
      @(negedge clk);
      chk({30'h0, cfg_req_to_user, cfg_req_done_internal}, {30'h0, exp}, "routing");
   endtask
   task automatic t_cfg();
      cfg_pulse(2'h2);
      axi_wr(12'h038, 32'h0000_0001, rs);
      chk({31'h0, internal_cfg_request_completion}, 32'h0000_0001, "terminate on");
      cfg_pulse(2'h1);
      axi_wr(12'h038, 32'h0000_0000, rs);
      cfg_pulse(2'h2);
      $display("routing test done");
   endtask
   task automatic t_msi();
      @(posedge clk);
      grant_code <= 3'h2;
      repeat (10) @(posedge clk);
      @(negedge clk);
      chk({29'h0, msi_granted_count}, 32'h0000_0002, "granted count");
      axi_rd(12'h014, rd, rs);
      chk({29'h0, rd[6:4]}, 32'h0000_0002, "granted field");
      $display("msi test done");
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'h0;
      t_const();
      t_map();
      t_ro_write();
      t_unmapped();
      t_cfg();
      t_msi();
      give_verdict();
   end
endmodule
`default_nettype wire
